// File: locond_pkg.sv
// Function
// - after information goes true, wait programmed on-delay, 0..9999 ms, default 0.
// - after information goes false, hold output for holding time, 0..9999 ms, default 0.
// - no-fault, brake, output, precharge, line contactor sources force on-delay to zero.
// - no-fault, brake, precharge, line contactor sources force holding time to zero.
// - per-output polarity: active-high drives 1 when true, active-low drives 0.
// - no-fault, brake, precharge, line contactor sources lock polarity active-high.
// - analog reuse output drives configured minimum for 0, maximum for 1.
// - source selector offers relay sources plus contactor, reel, wobble, precharge; default none.
package locond_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned TICK_US      = 1000;
   localparam int unsigned TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned MAX_MS       = 9999;
   localparam int unsigned MS_W         = 14;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL_A    = 8'h00;
   localparam logic [7:0] REG_ON_A      = 8'h04;
   localparam logic [7:0] REG_HOLD_A    = 8'h08;
   localparam logic [7:0] REG_CTRL_B    = 8'h0C;
   localparam logic [7:0] REG_ON_B      = 8'h10;
   localparam logic [7:0] REG_HOLD_B    = 8'h14;
   localparam logic [7:0] REG_ANA_MIN   = 8'h18;
   localparam logic [7:0] REG_ANA_MAX   = 8'h1C;
   localparam logic [7:0] REG_STATUS    = 8'h20;
   localparam logic [7:0] REG_SRCVEC    = 8'h24;
   // ctrl fields
   localparam int unsigned CTRL_SRC_LSB = 0;
   localparam int unsigned SRC_W        = 5;
   localparam int unsigned CTRL_NEG_BIT = 8;
   // reset values
   localparam logic [MS_W-1:0] ON_RST   = 14'h0000;
   localparam logic [MS_W-1:0] HOLD_RST = 14'h0000;
   localparam logic [15:0] ANA_MIN_RST  = 16'h0000;
   localparam logic [15:0] ANA_MAX_RST  = 16'hFFFF;
   // ---------------------------------------------------------------
   // source selector codes
   // ---------------------------------------------------------------
   localparam logic [4:0] SRC_NONE                       = 5'h00;
   localparam logic [4:0] SRC_NO_FAULT                   = 5'h01;
   localparam logic [4:0] SRC_BRAKE_CONTACTOR_SOURCE     = 5'h10;
   localparam logic [4:0] SRC_LINE_CONTACTOR_SOURCE      = 5'h11;
   localparam logic [4:0] SRC_OUTPUT_CONTACTOR_SOURCE    = 5'h12;
   localparam logic [4:0] SRC_END_OF_REEL_SOURCE         = 5'h13;
   localparam logic [4:0] SRC_COUNTER_WOBBLE_SYNC_SOURCE = 5'h14;
   localparam logic [4:0] SRC_DC_PRECHARGE_SOURCE        = 5'h15;
   localparam logic [4:0] SRC_RELAY_LAST                 = 5'h0F;
endpackage : locond_pkg

// File: locond_chan.sv
`timescale 1ns/100ps
module locond_chan #(
   parameter int unsigned MS_W = 14
) (
   // clock
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   input  wire logic            ce_i,
   input  wire logic            tick_i,
   // config
   input  wire logic            info_i,
   input  wire logic [MS_W-1:0] on_ms_i,
   input  wire logic [MS_W-1:0] hold_ms_i,
   input  wire logic            neg_i,
   // result
   output logic                 state_o,
   output logic                 pin_o
);
   typedef struct packed {
      logic            st;
      logic [MS_W-1:0] cnt;
      logic            pin;
   } locond_ch_s;
   locond_ch_s q_ff, nxt_q;

   if (MS_W < locond_pkg::MS_W) begin : g_width_check
      $error("MS_W too narrow for the longest delay");
   end

   always_comb begin
      nxt_q = q_ff;
      if (info_i == q_ff.st) begin
         nxt_q.cnt = '0;
      end else begin
         if ((info_i && q_ff.cnt >= on_ms_i) ||
             (!info_i && q_ff.cnt >= hold_ms_i)) begin
            nxt_q.st  = info_i;
            nxt_q.cnt = '0;
         end else if (tick_i) begin
            nxt_q.cnt = q_ff.cnt + 1'b1;
         end
      end
      nxt_q.pin = nxt_q.st ^ neg_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_ff <= '0;
      end else if (ce_i) begin
         q_ff <= nxt_q;
      end
   end

   assign state_o = q_ff.st;
   assign pin_o   = q_ff.pin;
endmodule : locond_chan

// File: locond_top.sv
`timescale 1ns/100ps
module locond_top (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // wishbone
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // information sources, indexed by selector code
   input  wire logic [31:0] src_i,
   // outputs
   output logic             expansion_logic_output_four_o,
   output logic             analog_reuse_logic_output_o,
   output logic      [15:0] first_analog_output_o
);
   localparam int unsigned W = locond_pkg::MS_W;

   typedef struct packed {
      logic [1:0][4:0]   src;
      logic [1:0]        neg;
      logic [1:0][W-1:0] on_ms;
      logic [1:0][W-1:0] hold_ms;
      logic [15:0]       ana_min;
      logic [15:0]       ana_max;
      logic [13:0]       tdiv;
      logic              tick;
      logic              ack;
      logic [31:0]       rdat;
      logic              lo4;
      logic              reuse;
      logic [15:0]       ana;
   } locond_s;
   locond_s q_ff, nxt_q;

   logic [1:0]        info;
   logic [1:0]        st;
   logic [1:0]        pin;
   logic [1:0][W-1:0] eff_on;
   logic [1:0][W-1:0] eff_hold;
   logic [1:0]        eff_neg;

   // ---------------------------------------------------------------
   // forced settings per channel
   // ---------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_ch
      logic lock4;
      logic lock_on;
      assign lock4 = q_ff.src[g] == locond_pkg::SRC_NO_FAULT ||
                     q_ff.src[g] == locond_pkg::SRC_BRAKE_CONTACTOR_SOURCE ||
                     q_ff.src[g] == locond_pkg::SRC_DC_PRECHARGE_SOURCE ||
                     q_ff.src[g] == locond_pkg::SRC_LINE_CONTACTOR_SOURCE;
      assign lock_on = lock4 ||
                       q_ff.src[g] == locond_pkg::SRC_OUTPUT_CONTACTOR_SOURCE;
      assign info[g]     = (q_ff.src[g] != locond_pkg::SRC_NONE) &&
                           src_i[q_ff.src[g]];
      assign eff_on[g]   = lock_on ? '0 : q_ff.on_ms[g];
      assign eff_hold[g] = lock4 ? '0 : q_ff.hold_ms[g];
      assign eff_neg[g]  = lock4 ? 1'b0 : q_ff.neg[g];
      locond_chan #(.MS_W(W)) u_chan (
         .clk_i     (clk_i),
         .rst_i     (rst_i),
         .ce_i      (ce_i),
         .tick_i    (q_ff.tick),
         .info_i    (info[g]),
         .on_ms_i   (eff_on[g]),
         .hold_ms_i (eff_hold[g]),
         .neg_i     (eff_neg[g]),
         .state_o   (st[g]),
         .pin_o     (pin[g])
      );
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [W-1:0] wv;
      wv    = W'(dat_i);
      nxt_q = q_ff;
      nxt_q.tick = 1'b0;
      if (q_ff.tdiv == 14'(locond_pkg::TICK_CYCLES - 1)) begin
         nxt_q.tdiv = '0;
         nxt_q.tick = 1'b1;
      end else begin
         nxt_q.tdiv = q_ff.tdiv + 1'b1;
      end
      if (dat_i > 32'(locond_pkg::MAX_MS)) begin
         wv = W'(locond_pkg::MAX_MS);
      end
      nxt_q.ack  = cyc_i && stb_i && !q_ff.ack;
      nxt_q.rdat = '0;
      if (cyc_i && stb_i && !q_ff.ack) begin
         unique case (adr_i)
            locond_pkg::REG_CTRL_A: nxt_q.rdat = {23'h0, q_ff.neg[0], 3'h0, q_ff.src[0]};
            locond_pkg::REG_CTRL_B: nxt_q.rdat = {23'h0, q_ff.neg[1], 3'h0, q_ff.src[1]};
            locond_pkg::REG_ON_A:   nxt_q.rdat = 32'(q_ff.on_ms[0]);
            locond_pkg::REG_ON_B:   nxt_q.rdat = 32'(q_ff.on_ms[1]);
            locond_pkg::REG_HOLD_A: nxt_q.rdat = 32'(q_ff.hold_ms[0]);
            locond_pkg::REG_HOLD_B: nxt_q.rdat = 32'(q_ff.hold_ms[1]);
            locond_pkg::REG_ANA_MIN: nxt_q.rdat = 32'(q_ff.ana_min);
            locond_pkg::REG_ANA_MAX: nxt_q.rdat = 32'(q_ff.ana_max);
            locond_pkg::REG_STATUS: nxt_q.rdat = {28'h0, pin, st};
            locond_pkg::REG_SRCVEC: nxt_q.rdat = src_i;
            default:                nxt_q.rdat = 32'h0000_0000;
         endcase
         if (we_i && sel_i[0]) begin
            unique case (adr_i)
               locond_pkg::REG_CTRL_A: begin
                  nxt_q.src[0] = dat_i[locond_pkg::CTRL_SRC_LSB +: locond_pkg::SRC_W];
                  nxt_q.neg[0] = dat_i[locond_pkg::CTRL_NEG_BIT];
               end
               locond_pkg::REG_CTRL_B: begin
                  nxt_q.src[1] = dat_i[locond_pkg::CTRL_SRC_LSB +: locond_pkg::SRC_W];
                  nxt_q.neg[1] = dat_i[locond_pkg::CTRL_NEG_BIT];
               end
               locond_pkg::REG_ON_A:    nxt_q.on_ms[0]   = wv;
               locond_pkg::REG_ON_B:    nxt_q.on_ms[1]   = wv;
               locond_pkg::REG_HOLD_A:  nxt_q.hold_ms[0] = wv;
               locond_pkg::REG_HOLD_B:  nxt_q.hold_ms[1] = wv;
               locond_pkg::REG_ANA_MIN: nxt_q.ana_min   = dat_i[15:0];
               locond_pkg::REG_ANA_MAX: nxt_q.ana_max   = dat_i[15:0];
               default: ;
            endcase
         end
      end
      nxt_q.lo4 = pin[0];
      nxt_q.reuse = pin[1];
      nxt_q.ana = pin[1] ? q_ff.ana_max : q_ff.ana_min;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_ff         <= '0;
         q_ff.ana_max <= locond_pkg::ANA_MAX_RST;
         q_ff.ana_min <= locond_pkg::ANA_MIN_RST;
      end else if (ce_i) begin
         q_ff <= nxt_q;
      end
   end

   assign expansion_logic_output_four_o = q_ff.lo4;
   assign analog_reuse_logic_output_o   = q_ff.reuse;
   assign first_analog_output_o         = q_ff.ana;
   assign dat_o = q_ff.rdat;
   assign ack_o = q_ff.ack;
endmodule : locond_top

// File: locond_checker.sv
`timescale 1ns/100ps
module locond_checker (
   // bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // sources and outputs
   input wire logic [31:0] src_i,
   input wire logic        expansion_logic_output_four_o,
   input wire logic [15:0] first_analog_output_o
);
   // ----
   // handshake and outputs
   // ----
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      cyc_i && stb_i && ce_i && !ack_o;
   endsequence
   sequence s_read(a);
      s_take ##0 (!we_i && adr_i == a);
   endsequence
   a_ack_follows: assert property (s_take |=> ack_o) else $error("no ack");
   a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o) else $error("long ack");
   a_ack_cause: assert property (ack_o && $past(ce_i) |-> $past(cyc_i && stb_i))
      else $error("stray ack");
   a_ce_no_take: assert property (!ce_i && !ack_o |=> !ack_o) else $error("ack while frozen");
   a_unmapped_zero: assert property (s_read(8'h28) |=> dat_o == 32'h0) else $error("bad read");
   a_src_vec: assert property (s_read(locond_pkg::REG_SRCVEC) |=> dat_o == $past(src_i))
      else $error("bad source vector");
   a_reset_idle:
      assert property (disable iff (1'b0) rst_i |=> !ack_o && !expansion_logic_output_four_o)
      else $error("not idle in reset");
   a_ce_freeze:
      assert property (!ce_i |=> $stable(expansion_logic_output_four_o)
         && $stable(first_analog_output_o)) else $error("output moved while frozen");
endmodule : locond_checker

bind locond_top locond_checker locond_checker_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
   .src_i(src_i), .expansion_logic_output_four_o(expansion_logic_output_four_o),
   .first_analog_output_o(first_analog_output_o));

// File: locond_load.sv
`timescale 1ns/100ps
module locond_load (
   // pin
   input  wire logic pin_i,
   // coil
   output logic      coil_o
);
   assign coil_o = pin_i;
endmodule : locond_load

// File: locond_top_tb.sv
`timescale 1ns/100ps
module locond_top_tb;
   logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, pin_o, reuse_o, coil, probe, lk;
   logic [3:0]  sel_i;
   logic [7:0]  adr_i;
   logic [15:0] ana_o, mn;
   logic [31:0] dat_i, dat_o, src_i, rq[$], pq[$];
   logic [4:0]  codes[8] = '{5'h01, 5'h05, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};
   int          error_cnt = 0, comparisons = 0, ticks = 0, seed = 97508;

   locond_top locond_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .src_i(src_i), .expansion_logic_output_four_o(pin_o),
      .analog_reuse_logic_output_o(reuse_o), .first_analog_output_o(ana_o));
   locond_load locond_load_i (.pin_i(pin_o), .coil_o(coil));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // ----
   // tasks
   // ----
   task end_of_test;
      if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test

   task cmp_data(input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected read data: expected %h seen %h", e, g);
      end
   endtask : cmp_data

   task cmp_out(input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected outputs: expected %h seen %h", e, g);
      end
   endtask : cmp_out

   task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      {cyc_i, stb_i, we_i} <= 3'b000;
   endtask : bus

   task rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(a, 1'b0, 32'h0);
   endtask : rd

   task look(input int n, input logic [31:0] e);
      repeat (n) @(posedge clk_i);
      pq.push_back(e);
      probe <= 1'b1;
      @(posedge clk_i);
      probe <= 1'b0;
   endtask : look

   task sig(input int b, input logic v);
      src_i <= $random(seed) & ~(32'h1 | 32'h1 << b) | {31'h0, v} << b;
   endtask : sig

   always @(posedge clk_i) begin
      ticks++;
      if (ticks == 90000) begin
         error_cnt++;
         end_of_test;
      end
      if (ack_o === 1'b1 && we_i === 1'b0) cmp_data(rq.pop_front(), dat_o);
      if (probe === 1'b1) cmp_out(pq.pop_front(), {14'h0, coil, reuse_o, ana_o});
   end
   // ----
   // sequence
   // ----
   initial begin
      {rst_i, ce_i, cyc_i, stb_i, we_i, probe, adr_i, sel_i, dat_i, src_i} = {2'b11, 80'h0};
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      ce_i <= 1'b0;
      look(3, 32'h0);
      ce_i <= 1'b1;
      rd(locond_pkg::REG_CTRL_A, 32'h0);
      rd(locond_pkg::REG_ON_A, 32'h0);
      rd(locond_pkg::REG_HOLD_B, 32'h0);
      rd(locond_pkg::REG_ANA_MAX, 32'h0000_FFFF);
      rd(8'h28, 32'h0);
      bus(locond_pkg::REG_ON_A, 1'b1, 32'h2);
      bus(locond_pkg::REG_HOLD_A, 1'b1, 32'h2);
      bus(locond_pkg::REG_CTRL_A, 1'b1, 32'h5);
      sig(5, 1'b1);
      look(9000, 32'h0);
      look(11200, 32'h2_0000);
      sig(5, 1'b0);
      look(9000, 32'h2_0000);
      sig(5, 1'b1);
      look(21000, 32'h2_0000);
      sig(5, 1'b0);
      look(21000, 32'h0);
      sig(18, 1'b0);
      bus(locond_pkg::REG_CTRL_A, 1'b1, 32'h112);
      look(4, 32'h2_0000);
      sig(18, 1'b1);
      look(4, 32'h0);
      sig(18, 1'b0);
      look(4, 32'h0);
      bus(locond_pkg::REG_CTRL_A, 1'b1, 32'h110);
      sig(16, 1'b1);
      look(4, 32'h2_0000);
      sig(16, 1'b0);
      look(4, 32'h0);
      bus(locond_pkg::REG_CTRL_A, 1'b1, 32'h0);
      mn = 16'($random(seed));
      bus(locond_pkg::REG_ANA_MIN, 1'b1, {16'h0, mn});
      bus(locond_pkg::REG_ANA_MAX, 1'b1, {16'h0, ~mn});
      foreach (codes[i]) begin
         lk = codes[i] inside {5'h01, 5'h10, 5'h11, 5'h15};
         bus(locond_pkg::REG_CTRL_B, 1'b1, {23'h0, 1'b1, 3'h0, codes[i]});
         sig(codes[i], 1'b1);
         look(4, {15'h0, lk, lk ? ~mn : mn});
         sig(codes[i], 1'b0);
         look(4, {15'h0, !lk, lk ? mn : ~mn});
      end
      rd(locond_pkg::REG_SRCVEC, src_i);
      bus(locond_pkg::REG_ON_B, 1'b1, 32'h0001_0000);
      rd(locond_pkg::REG_ON_B, 32'(locond_pkg::MAX_MS));
      rd(locond_pkg::REG_STATUS, 32'h0);
      @(posedge clk_i);
      end_of_test;
   end
endmodule : locond_top_tb
